//--- core/irq_bank_cfg.svh
// address map, field positions and reset values of the request and enable bank
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH
`define ADDR_ENABLE_0     12'h090
`define ADDR_ENABLE_1     12'h091
`define ADDR_ENABLE_2     12'h092
`define ADDR_ENABLE_3     12'h093
`define ADDR_ENABLE_4     12'h094
`define ADDR_REQUEST_4    12'h014
`define ADDR_MODE         12'h0a0
`define RESET_BYTE        8'h00
`define ENABLE_0_MASK     8'h31
`define BIT_CAPA          2
`define BIT_CAPB          3
`define BIT_TMR_OVF       4
`define BIT_TMR_GATE      5
`define BIT_WG_ONE        6
`define BIT_WG_TWO        7
`define MODE_A_LSB        0
`define MODE_B_LSB        2
`define MODE_CAPTURE      2'h0
`define MODE_COMPARE      2'h1
`define MODE_PWM          2'h2
`define MODE_NONE         2'h3
`define MODE_RESET        4'h0
`define HIST_RESET        2'h0
`define ENABLE_COUNT      5
`define OTHER_REQ_MASK    8'h03
`endif

//--- core/irq_bank_pkg.sv
// types shared by the request and enable bank
package irq_bank_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [11:0] addr_t;
    typedef logic [1:0]  capmode_t;
endpackage

//--- core/capunit_event_sel.sv
// selects the request event of one capture unit from its operating mode
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module capunit_event_sel (
    input  wire logic                 clk_sys,      // system clock
    input  wire logic                 rst_n,        // synchronous reset, low
    input  wire irq_bank_pkg::capmode_t modeSel,    // capunit_operating_mode
    input  wire logic                 captureEvt,   // capture event pulse
    input  wire logic                 compareEvt,   // compare match pulse
    input  wire logic                 pwmOut,       // pwm output level
    output logic                      requestEvt    // one-cycle request
);
    logic pwmPrev_q;
    logic pwmPrev_d;

    always_comb begin
        pwmPrev_d = pwmOut;
        unique case (modeSel)
            `MODE_CAPTURE: requestEvt = captureEvt;
            `MODE_COMPARE: requestEvt = compareEvt;
            `MODE_PWM:     requestEvt = pwmPrev_q & ~pwmOut;
            `MODE_NONE:    requestEvt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwmPrev_q <= 1'b0;
        end else begin
            pwmPrev_q <= pwmPrev_d;
        end
    end

    a_pwm_trailing_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (modeSel == `MODE_PWM && $fell(pwmOut) && $past(rst_n)) |-> requestEvt)
        else $error("pwm trailing edge gave no request");
endmodule

//--- core/peripheral_irq_flag_bank.sv
// request flag and enable register bank of the peripheral interrupt group
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module peripheral_irq_flag_bank (
    input  wire logic                 clk_sys,       // system clock, 40 MHz
    input  wire logic                 rst_n,         // synchronous reset, low
    input  wire irq_bank_pkg::addr_t  regAddr,       // register address
    input  wire irq_bank_pkg::byte_t  regWdata,      // write data
    input  wire logic                 regWr,         // write strobe
    input  wire logic                 regRd,         // read strobe
    output irq_bank_pkg::byte_t       regRdata,      // read data, next cycle
    input  wire logic                 capAEvtCap,    // unit a capture pulse
    input  wire logic                 capAEvtCmp,    // unit a compare pulse
    input  wire logic                 capAPwm,       // unit a pwm level
    input  wire logic                 capBEvtCap,    // unit b capture pulse
    input  wire logic                 capBEvtCmp,    // unit b compare pulse
    input  wire logic                 capBPwm,       // unit b pwm level
    input  wire logic                 timerOverflow, // timer five overflow pulse
    input  wire logic                 timerGateOff,  // timer five gate closed pulse
    input  wire logic                 wgOneShutdown, // generator one shutdown level
    input  wire logic                 wgTwoShutdown, // generator two shutdown level
    input  wire irq_bank_pkg::byte_t  otherRequests, // bits 1:0 requests of units 1,2
    output logic                      irqOut         // level interrupt
);
    irq_bank_pkg::byte_t enable_q [`ENABLE_COUNT];
    irq_bank_pkg::byte_t enable_d [`ENABLE_COUNT];
    irq_bank_pkg::byte_t request_q;
    irq_bank_pkg::byte_t request_d;
    irq_bank_pkg::byte_t rdata_q;
    irq_bank_pkg::byte_t rdata_d;
    logic [3:0]          mode_q;
    logic [3:0]          mode_d;
    logic [1:0]          wgPrev_q;
    logic [1:0]          wgPrev_d;
    logic                capAReq;
    logic                capBReq;
    irq_bank_pkg::byte_t setBits;

    function automatic logic isEnable(input irq_bank_pkg::addr_t a, input int idx);
        isEnable = (a == (`ADDR_ENABLE_0 + idx[11:0]));
    endfunction

    // true for every location that holds a register of this bank
    function automatic logic isMapped(input irq_bank_pkg::addr_t a);
        isMapped = (a == `ADDR_REQUEST_4) || (a == `ADDR_MODE);
        for (int i = 0; i < `ENABLE_COUNT; i++) begin
            isMapped = isMapped || isEnable(a, i);
        end
    endfunction

    capunit_event_sel capA (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .modeSel    (mode_q[`MODE_A_LSB +: 2]),
        .captureEvt (capAEvtCap),
        .compareEvt (capAEvtCmp),
        .pwmOut     (capAPwm),
        .requestEvt (capAReq)
    );

    capunit_event_sel capB (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .modeSel    (mode_q[`MODE_B_LSB +: 2]),
        .captureEvt (capBEvtCap),
        .compareEvt (capBEvtCmp),
        .pwmOut     (capBPwm),
        .requestEvt (capBReq)
    );

    always_comb begin
        setBits = otherRequests & `OTHER_REQ_MASK;
        setBits[`BIT_CAPA]     = capAReq;
        setBits[`BIT_CAPB]     = capBReq;
        setBits[`BIT_TMR_OVF]  = timerOverflow;
        setBits[`BIT_TMR_GATE] = timerGateOff;
        setBits[`BIT_WG_ONE]   = wgOneShutdown & ~wgPrev_q[0];
        setBits[`BIT_WG_TWO]   = wgTwoShutdown & ~wgPrev_q[1];
        wgPrev_d = {wgTwoShutdown, wgOneShutdown};
    end

    always_comb begin
        for (int i = 0; i < `ENABLE_COUNT; i++) begin
            enable_d[i] = enable_q[i];
            if (regWr && isEnable(regAddr, i)) begin
                enable_d[i] = regWdata;
            end
        end
        // enable 0 keeps only its three implemented bits
        enable_d[0] = enable_d[0] & `ENABLE_0_MASK;
    end

    always_comb begin
        mode_d = mode_q;
        if (regWr && regAddr == `ADDR_MODE) begin
            mode_d = regWdata[3:0];
        end
    end

    always_comb begin
        // write one clears, a set in the same cycle wins
        request_d = request_q;
        if (regWr && regAddr == `ADDR_REQUEST_4) begin
            request_d = request_q & ~regWdata;
        end
        request_d = request_d | setBits;
    end

    always_comb begin
        rdata_d = `RESET_BYTE;
        if (regRd) begin
            for (int i = 0; i < `ENABLE_COUNT; i++) begin
                if (isEnable(regAddr, i)) begin
                    rdata_d = enable_q[i];
                end
            end
            if (regAddr == `ADDR_REQUEST_4) begin
                rdata_d = request_q;
            end
            if (regAddr == `ADDR_MODE) begin
                rdata_d = {4'h0, mode_q};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < `ENABLE_COUNT; i++) begin
                enable_q[i] <= `RESET_BYTE;
            end
        end else begin
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            request_q <= `RESET_BYTE;
        end else begin
            request_q <= request_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= `RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_q <= `MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wgPrev_q <= `HIST_RESET;
        end else begin
            wgPrev_q <= wgPrev_d;
        end
    end

    assign regRdata = rdata_q;
    assign irqOut   = |(request_q & enable_q[4]);

    sequence s_overflow;
        timerOverflow;
    endsequence

    a_overflow_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_overflow |=> request_q[`BIT_TMR_OVF])
        else $error("timer overflow flag not set");

    a_overflow_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (request_q[`BIT_TMR_OVF] && !(regWr && regAddr == `ADDR_REQUEST_4))
        |=> request_q[`BIT_TMR_OVF])
        else $error("overflow flag dropped without a clear");

    a_capa_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_A_LSB +: 2] == `MODE_CAPTURE && capAEvtCap) |=> request_q[`BIT_CAPA])
        else $error("capture event missed on unit a");

    a_capb_compare_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_B_LSB +: 2] == `MODE_COMPARE && capBEvtCmp) |=> request_q[`BIT_CAPB])
        else $error("compare match missed on unit b");

    a_wg_shutdown_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(wgOneShutdown) |=> request_q[`BIT_WG_ONE])
        else $error("shutdown did not set generator one flag");

    a_unmapped_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRd && !isMapped(regAddr)) |=> regRdata == `RESET_BYTE)
        else $error("unmapped address read nonzero");

    a_enable0_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enable_q[0] & ~`ENABLE_0_MASK) == 8'h00)
        else $error("reserved enable bits set");

    a_irq_follows_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (timerOverflow && enable_q[4][`BIT_TMR_OVF] && !regWr) |=> irqOut)
        else $error("unmasked overflow gave no interrupt");

    // pwm level high, then low in pwm mode: a trailing edge
    sequence s_capa_pwm_fall;
        capAPwm ##1 (mode_q[`MODE_A_LSB +: 2] == `MODE_PWM && !capAPwm);
    endsequence

    sequence s_capb_pwm_fall;
        capBPwm ##1 (mode_q[`MODE_B_LSB +: 2] == `MODE_PWM && !capBPwm);
    endsequence

    a_capa_compare_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_A_LSB +: 2] == `MODE_COMPARE && capAEvtCmp) |=> request_q[`BIT_CAPA])
        else $error("compare match missed on unit a");

    a_capb_capture_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_B_LSB +: 2] == `MODE_CAPTURE && capBEvtCap) |=> request_q[`BIT_CAPB])
        else $error("capture event missed on unit b");

    a_capa_pwm_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_capa_pwm_fall |=> request_q[`BIT_CAPA])
        else $error("pwm trailing edge missed on unit a");

    a_capb_pwm_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_capb_pwm_fall |=> request_q[`BIT_CAPB])
        else $error("pwm trailing edge missed on unit b");

    a_capa_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_A_LSB +: 2] == `MODE_NONE && !request_q[`BIT_CAPA]) |=> !request_q[`BIT_CAPA])
        else $error("unit a flag set with no event selected");

    a_capb_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q[`MODE_B_LSB +: 2] == `MODE_NONE && !request_q[`BIT_CAPB]) |=> !request_q[`BIT_CAPB])
        else $error("unit b flag set with no event selected");

    a_overflow_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_REQUEST_4 && regWdata[`BIT_TMR_OVF] && !timerOverflow)
        |=> !request_q[`BIT_TMR_OVF])
        else $error("overflow flag survived its clear");

    a_gate_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timerGateOff |=> request_q[`BIT_TMR_GATE])
        else $error("gate closure flag not set");

    a_gate_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_REQUEST_4 && regWdata[`BIT_TMR_GATE] && !timerGateOff)
        |=> !request_q[`BIT_TMR_GATE])
        else $error("gate flag survived its clear");

    a_wg_two_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(wgTwoShutdown) |=> request_q[`BIT_WG_TWO])
        else $error("shutdown did not set generator two flag");

    a_wg_one_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wgOneShutdown && !request_q[`BIT_WG_ONE]) |=> !request_q[`BIT_WG_ONE])
        else $error("generator one flag set while running");

    a_wg_one_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_REQUEST_4 && regWdata[`BIT_WG_ONE] && !wgOneShutdown)
        |=> !request_q[`BIT_WG_ONE])
        else $error("generator one flag survived its clear");

    a_wg_two_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_REQUEST_4 && regWdata[`BIT_WG_TWO] && !wgTwoShutdown)
        |=> !request_q[`BIT_WG_TWO])
        else $error("generator two flag survived its clear");

    a_unmapped_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && !isMapped(regAddr))
        |=> (enable_q[4] == $past(enable_q[4]) && mode_q == $past(mode_q)))
        else $error("write to an unmapped address changed state");

    a_enable0_write_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_ENABLE_0)
        |=> enable_q[0] == ($past(regWdata) & `ENABLE_0_MASK))
        else $error("enable 0 write not masked");

    a_enable_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_ENABLE_1) |=> enable_q[1] == $past(regWdata))
        else $error("enable 1 write lost");

    a_mode_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_MODE) |=> mode_q == $past(regWdata[3:0]))
        else $error("mode write lost");

    a_read_request_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRd && regAddr == `ADDR_REQUEST_4) |=> regRdata == $past(request_q))
        else $error("request read returned wrong data");

    a_read_enable_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRd && regAddr == `ADDR_ENABLE_4) |=> regRdata == $past(enable_q[4]))
        else $error("enable 4 read returned wrong data");

    a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !regRd |=> regRdata == `RESET_BYTE)
        else $error("read data not zero outside a read");

    a_irq_masked_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && regAddr == `ADDR_ENABLE_4 && regWdata == `RESET_BYTE) |=> !irqOut)
        else $error("interrupt stayed high with every source masked");

    // a reset cycle must leave the request flags, the read data and the interrupt cleared
    a_reset_clears: assert property (@(posedge clk_sys)
        !rst_n |=> (request_q == `RESET_BYTE && regRdata == `RESET_BYTE && !irqOut))
        else $error("reset left the bank set");
endmodule

//--- tb/tb_top.sv
// self-checking bench of the request flag and enable bank
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module tb_top;
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    irq_bank_pkg::addr_t regAddr = 12'h000;
    irq_bank_pkg::byte_t regWdata = 8'h00;
    logic                regWr = 1'b0;
    logic                regRd = 1'b0;
    irq_bank_pkg::byte_t regRdata;
    logic [9:0]          evt = 10'h000;
    irq_bank_pkg::byte_t otherRequests = 8'h00;
    logic                irqOut;
    logic                rdLate = 1'b0;
    integer              errors = 0;
    integer              n_compared = 0;
    integer              seed = 32'h179f;
    irq_bank_pkg::byte_t expQ[$];
    irq_bank_pkg::byte_t v;

    always #12.5 clk_sys = ~clk_sys;

    peripheral_irq_flag_bank i_peripheral_irq_flag_bank (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .capAEvtCap(evt[0]), .capAEvtCmp(evt[1]), .capAPwm(evt[2]),
        .capBEvtCap(evt[3]), .capBEvtCmp(evt[4]), .capBPwm(evt[5]),
        .timerOverflow(evt[6]), .timerGateOff(evt[7]),
        .wgOneShutdown(evt[8]), .wgTwoShutdown(evt[9]),
        .otherRequests(otherRequests), .irqOut(irqOut)
    );

    task automatic check(input string               name,
                         input irq_bank_pkg::byte_t seen,
                         input irq_bank_pkg::byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task wr(input irq_bank_pkg::addr_t a, input irq_bank_pkg::byte_t d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask

    task rd(input irq_bank_pkg::addr_t a, input irq_bank_pkg::byte_t exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        expQ.push_back(exp);
        @(posedge clk_sys);
        regRd   <= 1'b0;
    endtask

    task pulse(input int b);
        @(posedge clk_sys);
        evt <= 10'h001 << b;
        @(posedge clk_sys);
        evt <= 10'h000;
    endtask

    // read data stand only in the cycle after the read strobe
    always @(posedge clk_sys) rdLate <= regRd;
    always @(negedge clk_sys) begin
        if (rdLate && expQ.size() > 0) begin
            check("regRdata", regRdata, expQ.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(`ADDR_ENABLE_0 + 12'(i), `RESET_BYTE);
        rd(`ADDR_REQUEST_4, `RESET_BYTE);
        for (int i = 0; i < 5; i++) begin
            v = 8'($random(seed));
            wr(`ADDR_ENABLE_0 + 12'(i), v);
            rd(`ADDR_ENABLE_0 + 12'(i), (i == 0) ? (v & `ENABLE_0_MASK) : v);
        end
        wr(`ADDR_ENABLE_4, 8'h00);
        wr(12'h095, 8'hff);
        rd(12'h095, 8'h00);
        rd(12'h08f, 8'h00);
        rd(`ADDR_ENABLE_4, 8'h00);
        rd(12'h0a1, 8'h00);
        // each unit, each mode: only the event of the selected mode raises the flag
        for (int u = 0; u < 2; u++) begin
            for (int m = 0; m < 4; m++) begin
                wr(`ADDR_MODE, 8'(m << (2 * u)) | 8'(8'h0c >> (2 * u)));
                for (int k = 0; k < 3; k++) begin
                    pulse(3 * u + k);
                    rd(`ADDR_REQUEST_4, (k == m) ? 8'(1 << (2 + u)) : 8'h00);
                    rd(`ADDR_REQUEST_4, (k == m) ? 8'(1 << (2 + u)) : 8'h00);
                    wr(`ADDR_REQUEST_4, 8'hff);
                end
            end
        end
        for (int k = 6; k < 10; k++) begin
            pulse(k);
            rd(`ADDR_REQUEST_4, 8'(1 << (k - 2)));
            wr(`ADDR_REQUEST_4, 8'(1 << (k - 2)));
            rd(`ADDR_REQUEST_4, 8'h00);
        end
        @(posedge clk_sys);
        otherRequests <= 8'($random(seed)) & 8'hfc;
        @(posedge clk_sys);
        otherRequests <= 8'h03;
        @(posedge clk_sys);
        otherRequests <= 8'h00;
        rd(`ADDR_REQUEST_4, 8'h03);
        wr(`ADDR_REQUEST_4, 8'hff);
        pulse(6);
        @(negedge clk_sys);
        check("irqOut", {7'h00, irqOut}, 8'h00);
        wr(`ADDR_ENABLE_4, 8'h10);
        @(negedge clk_sys);
        check("irqOut", {7'h00, irqOut}, 8'h01);
        wr(`ADDR_REQUEST_4, 8'h10);
        @(negedge clk_sys);
        check("irqOut", {7'h00, irqOut}, 8'h00);
        pulse(6);
        @(negedge clk_sys);
        check("irqOut", {7'h00, irqOut}, 8'h01);
        // a reset in mid-run clears flags, enables and the interrupt
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check("irqOut", {7'h00, irqOut}, 8'h00);
        rd(`ADDR_ENABLE_4, `RESET_BYTE);
        rd(`ADDR_REQUEST_4, `RESET_BYTE);
        repeat (2) @(posedge clk_sys);
        check("pending", 8'(expQ.size()), 8'h00);
        close_out();
    end
endmodule
